// >>> tpdc_clock_cfg.sv
// tpdc_clock_cfg.sv: register block for three PLLs behind an AXI4-Lite slave
// assumes one clock, synchronous active-low reset, and a master keeping AXI rules
//
// Decided for this implementation: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "tpdc_defs.svh"

module tpdc_clock_cfg #(
	parameter int unsigned FIN_HZ = 12000000
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// register bus
	input wire tpdc_pkg::tpdc_axil_req_t axiReq,
	output tpdc_pkg::tpdc_axil_rsp_t axiRsp,
	// fields to the PLL circuits
	output tpdc_pkg::tpdc_pll_cfg_t srcPllCfg,
	output tpdc_pkg::tpdc_pll_cfg_t memPllCfg,
	output tpdc_pkg::tpdc_pll_cfg_t corePllCfg,
	output logic [2:0] srcExtraDiv,
	// nominal frequencies
	output logic [31:0] srcPllHz,
	output logic [31:0] scanClockHz,
	output logic [31:0] memClockHz,
	output logic [31:0] coreClockHz,
	// lock wait in progress per PLL
	output logic [2:0] pllSettling
);
	import tpdc_pkg::*;

	localparam int PLLS = 3;
	localparam int CNT_W = `TPDC_LOCK_CNT_W;
	localparam logic [CNT_W-1:0] LOCK_CYCLES = CNT_W'(`TPDC_LOCK_CYCLES);

	function automatic logic [7:0] regIndex(input logic [7:0] addr);
		regIndex = {2'h0, addr[7:2]};
	endfunction

	function automatic logic isPllReg(input logic [7:0] idx);
		isPllReg = (idx >= `TPDC_IDX_SRC_LOW) && (idx <= `TPDC_IDX_CORE_MULT);
	endfunction

	function automatic logic isMultReg(input logic [7:0] idx);
		isMultReg = (idx == `TPDC_IDX_SRC_MULT) || (idx == `TPDC_IDX_MEM_MULT) || (idx == `TPDC_IDX_CORE_MULT);
	endfunction

	function automatic logic [1:0] pllOf(input logic [7:0] idx);
		case (idx)
			`TPDC_IDX_SRC_LOW, `TPDC_IDX_SRC_MULT: pllOf = `TPDC_PLL_SRC;
			`TPDC_IDX_MEM_LOW, `TPDC_IDX_MEM_MULT: pllOf = `TPDC_PLL_MEM;
			`TPDC_IDX_CORE_LOW, `TPDC_IDX_CORE_MULT: pllOf = `TPDC_PLL_CORE;
			default: pllOf = `TPDC_PLL_SRC;
		endcase
	endfunction

	function automatic tpdc_pll_cfg_t resetCfg(input int k);
		resetCfg.preDiv = `TPDC_PRE_RST;
		case (k)
			0: begin
				resetCfg.outDiv = `TPDC_SRC_OUT_RST;
				resetCfg.multiplier = `TPDC_SRC_MULT_RST;
			end
			1: begin
				resetCfg.outDiv = `TPDC_MEM_OUT_RST;
				resetCfg.multiplier = `TPDC_MEM_MULT_RST;
			end
			default: begin
				resetCfg.outDiv = `TPDC_CORE_OUT_RST;
				resetCfg.multiplier = `TPDC_CORE_MULT_RST;
			end
		endcase
	endfunction

	// register storage
	tpdc_pll_cfg_t cfgStore [PLLS];
	logic [2:0] extraDiv;
	logic [CNT_W-1:0] settleCount [PLLS];
	logic [CNT_W-1:0] next_settleCount [PLLS];

	// write channel state
	logic awReady;
	logic wReady;
	logic awHeld;
	logic wHeld;
	logic [7:0] awIdx;
	logic [31:0] wDataHeld;
	logic [3:0] wStrbHeld;
	logic bValid;
	logic [1:0] bResp;
	logic wrFire;
	logic pllWrite;

	// read channel state
	logic arReady;
	logic rValid;
	logic [31:0] rData;
	logic [1:0] rResp;
	logic [7:0] rdIdx;
	logic [7:0] arIdx;
	logic [31:0] next_rData;
	logic [1:0] next_rResp;

	assign wrFire = awHeld && wHeld && !bValid;
	assign pllWrite = wrFire && wStrbHeld[0] && isPllReg(awIdx);
	assign arIdx = regIndex(axiReq.araddr);

	assign axiRsp = '{awready: awReady, wready: wReady, bvalid: bValid, bresp: bResp,
		arready: arReady, rvalid: rValid, rdata: rData, rresp: rResp};

	// write address acceptance
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			awHeld <= 1'b0;
			awReady <= 1'b0;
			awIdx <= 8'h00;
		end else if (axiReq.awvalid && awReady) begin
			awHeld <= 1'b1;
			awReady <= 1'b0;
			awIdx <= regIndex(axiReq.awaddr);
		end else begin
			if (wrFire) begin
				awHeld <= 1'b0;
			end
			awReady <= !awHeld && !bValid;
		end
	end

	// write data acceptance
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			wHeld <= 1'b0;
			wReady <= 1'b0;
			wDataHeld <= 32'h0;
			wStrbHeld <= 4'h0;
		end else if (axiReq.wvalid && wReady) begin
			wHeld <= 1'b1;
			wReady <= 1'b0;
			wDataHeld <= axiReq.wdata;
			wStrbHeld <= axiReq.wstrb;
		end else begin
			if (wrFire) begin
				wHeld <= 1'b0;
			end
			wReady <= !wHeld && !bValid;
		end
	end

	// write response
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			bValid <= 1'b0;
			bResp <= `TPDC_RESP_OKAY;
		end else if (wrFire) begin
			bValid <= 1'b1;
			bResp <= (isPllReg(awIdx) || awIdx == `TPDC_IDX_STATUS) ? `TPDC_RESP_OKAY : `TPDC_RESP_SLVERR;
		end else if (axiReq.bready) begin
			bValid <= 1'b0;
		end
	end

	// field storage; read-only positions are simply not stored
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			for (int k = 0; k < PLLS; k++) begin
				cfgStore[k] <= resetCfg(k);
			end
		end else if (pllWrite && isMultReg(awIdx)) begin
			cfgStore[pllOf(awIdx)].multiplier <= wDataHeld[`TPDC_MULT_MSB:`TPDC_MULT_LSB];
		end else if (pllWrite) begin
			cfgStore[pllOf(awIdx)].outDiv <= wDataHeld[`TPDC_OUT_MSB:`TPDC_OUT_LSB];
			cfgStore[pllOf(awIdx)].preDiv <= wDataHeld[`TPDC_PRE_BIT];
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			extraDiv <= `TPDC_EXTRA_RST;
		end else if (pllWrite && awIdx == `TPDC_IDX_SRC_LOW) begin
			extraDiv <= wDataHeld[`TPDC_EXTRA_MSB:`TPDC_EXTRA_LSB];
		end
	end

	// lock wait counters, restarted by any write to a PLL's registers with byte lane zero enabled
	always_comb begin
		for (int k = 0; k < PLLS; k++) begin
			if (pllWrite && pllOf(awIdx) == 2'(k)) begin
				next_settleCount[k] = LOCK_CYCLES;
			end else if (settleCount[k] != '0) begin
				next_settleCount[k] = settleCount[k] - 1'b1;
			end else begin
				next_settleCount[k] = settleCount[k];
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		for (int k = 0; k < PLLS; k++) begin
			if (!rst_n) begin
				settleCount[k] <= '0;
				pllSettling[k] <= 1'b0;
			end else begin
				settleCount[k] <= next_settleCount[k];
				pllSettling[k] <= next_settleCount[k] != '0;
			end
		end
	end

	// read decode; unused bits read zero
	always_comb begin
		next_rData = 32'h0;
		next_rResp = `TPDC_RESP_OKAY;
		case (arIdx)
			`TPDC_IDX_SRC_LOW: next_rData = {26'h0, extraDiv, cfgStore[`TPDC_PLL_SRC].outDiv,
				cfgStore[`TPDC_PLL_SRC].preDiv};
			`TPDC_IDX_SRC_MULT: next_rData = {26'h0, cfgStore[`TPDC_PLL_SRC].multiplier};
			`TPDC_IDX_MEM_LOW: next_rData = {29'h0, cfgStore[`TPDC_PLL_MEM].outDiv, cfgStore[`TPDC_PLL_MEM].preDiv};
			`TPDC_IDX_MEM_MULT: next_rData = {26'h0, cfgStore[`TPDC_PLL_MEM].multiplier};
			`TPDC_IDX_CORE_LOW: next_rData = {29'h0, cfgStore[`TPDC_PLL_CORE].outDiv, cfgStore[`TPDC_PLL_CORE].preDiv};
			`TPDC_IDX_CORE_MULT: next_rData = {26'h0, cfgStore[`TPDC_PLL_CORE].multiplier};
			`TPDC_IDX_STATUS: next_rData = {29'h0, pllSettling};
			default: next_rResp = `TPDC_RESP_SLVERR;
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			arReady <= 1'b0;
			rValid <= 1'b0;
			rData <= 32'h0;
			rResp <= `TPDC_RESP_OKAY;
			rdIdx <= 8'h00;
		end else if (axiReq.arvalid && arReady) begin
			arReady <= 1'b0;
			rValid <= 1'b1;
			rData <= next_rData;
			rResp <= next_rResp;
			rdIdx <= arIdx;
		end else begin
			if (axiReq.rready) begin
				rValid <= 1'b0;
			end
			arReady <= !rValid;
		end
	end

	// fields straight to the PLL circuits
	assign srcPllCfg = cfgStore[`TPDC_PLL_SRC];
	assign memPllCfg = cfgStore[`TPDC_PLL_MEM];
	assign corePllCfg = cfgStore[`TPDC_PLL_CORE];
	assign srcExtraDiv = extraDiv;

	// frequency of each PLL output
	logic [31:0] pllHz [PLLS];

	genvar g;
	generate
		for (g = 0; g < PLLS; g++) begin : pllFreqGen
			tpdc_pll_freq #(
				.FIN_HZ(FIN_HZ)
			) uPllFreq (
				.clk_sys(clk_sys),
				.rst_n(rst_n),
				.cfg(cfgStore[g]),
				.extraShift(3'h0),
				.freqHz(pllHz[g])
			);
		end
	endgenerate

	// scan clock taken from the source PLL through the extra divider
	tpdc_pll_freq #(
		.FIN_HZ(FIN_HZ)
	) uScanFreq (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.cfg(cfgStore[`TPDC_PLL_SRC]),
		.extraShift(tpdc_extra_shift(extraDiv)),
		.freqHz(scanClockHz)
	);

	assign srcPllHz = pllHz[`TPDC_PLL_SRC];
	assign memClockHz = pllHz[`TPDC_PLL_MEM];
	assign coreClockHz = pllHz[`TPDC_PLL_CORE];

	AST_EXTRA_DIV16: assert property (@(posedge clk_sys) disable iff (!rst_n)
		extraDiv[0] && $stable(extraDiv) && $stable(cfgStore[`TPDC_PLL_SRC]) |=> scanClockHz == (srcPllHz >> 4))
		else $error("extra divider code xx1 does not divide by 16");

	AST_EXTRA_POW2: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!extraDiv[0] && $stable(extraDiv) && $stable(cfgStore[`TPDC_PLL_SRC])
			|=> scanClockHz == (srcPllHz >> $past(extraDiv[2:1])))
		else $error("scan clock is not the source PLL over the extra divider");

	AST_RESET_SRC: assert property (@(posedge clk_sys)
		!rst_n |=> srcPllCfg.outDiv == `TPDC_SRC_OUT_RST && srcPllCfg.preDiv == `TPDC_PRE_RST
			&& srcPllCfg.multiplier == `TPDC_SRC_MULT_RST && srcExtraDiv == `TPDC_EXTRA_RST)
		else $error("source PLL fields wrong after reset");

	AST_RESET_MEM: assert property (@(posedge clk_sys)
		!rst_n |=> memPllCfg.outDiv == `TPDC_MEM_OUT_RST && memPllCfg.preDiv == `TPDC_PRE_RST
			&& memPllCfg.multiplier == `TPDC_MEM_MULT_RST)
		else $error("memory PLL fields wrong after reset");

	AST_RESET_CORE: assert property (@(posedge clk_sys)
		!rst_n |=> corePllCfg.outDiv == `TPDC_CORE_OUT_RST && corePllCfg.preDiv == `TPDC_PRE_RST
			&& corePllCfg.multiplier == `TPDC_CORE_MULT_RST)
		else $error("core PLL fields wrong after reset");

	AST_CORE_LOW_WRITE: assert property (@(posedge clk_sys) disable iff (!rst_n)
		pllWrite && awIdx == `TPDC_IDX_CORE_LOW
			|=> corePllCfg.outDiv == $past(wDataHeld[`TPDC_OUT_MSB:`TPDC_OUT_LSB])
			&& corePllCfg.preDiv == $past(wDataHeld[`TPDC_PRE_BIT]))
		else $error("core PLL low fields not taken from the write");

	AST_MEM_MULT_WRITE: assert property (@(posedge clk_sys) disable iff (!rst_n)
		pllWrite && awIdx == `TPDC_IDX_MEM_MULT ##1 !pllWrite [*2]
			|-> memPllCfg.multiplier == $past(wDataHeld[`TPDC_MULT_MSB:`TPDC_MULT_LSB], 2))
		else $error("memory multiplier not held from the write");

	AST_LOW_RO_ZERO: assert property (@(posedge clk_sys) disable iff (!rst_n)
		rValid && (rdIdx == `TPDC_IDX_MEM_LOW || rdIdx == `TPDC_IDX_CORE_LOW) |-> rData[31:3] == 29'h0)
		else $error("read-only bits of a low register read nonzero");

	AST_MULT_UPPER_ZERO: assert property (@(posedge clk_sys) disable iff (!rst_n)
		rValid && (isMultReg(rdIdx) || rdIdx == `TPDC_IDX_SRC_LOW) |-> rData[31:6] == 26'h0)
		else $error("multiplier or source upper bits read nonzero");

	AST_SETTLE_HOLD: assert property (@(posedge clk_sys) disable iff (!rst_n)
		pllWrite && pllOf(awIdx) == `TPDC_PLL_MEM |=> pllSettling[1] [*8])
		else $error("memory PLL lock wait not started by a write");

	AST_BVALID_HOLD: assert property (@(posedge clk_sys) disable iff (!rst_n)
		bValid && !axiReq.bready |=> bValid && $stable(bResp))
		else $error("write response dropped before bready");

endmodule
`default_nettype wire

// >>> tpdc_clock_cfg_tb_top.sv
// tpdc_clock_cfg_tb_top.sv: self-checking bench for the PLL configuration register block
// assumes the design files and tpdc_defs.svh are compiled before it
`timescale 1ns/1ps
`default_nettype none
`include "tpdc_defs.svh"

module tpdc_clock_cfg_tb_top;
	import tpdc_pkg::*;

	localparam int unsigned FIN = 12000000;

	typedef struct {
		logic [7:0] addr;
		logic [31:0] wdata;
		logic [7:0] rdExp;
	} tpdc_row_t;

	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	tpdc_axil_req_t axiReq = '0;
	tpdc_axil_rsp_t axiRsp;
	tpdc_pll_cfg_t srcCfg;
	tpdc_pll_cfg_t memCfg;
	tpdc_pll_cfg_t coreCfg;
	logic [2:0] srcExtraDiv;
	logic [31:0] srcPllHz;
	logic [31:0] scanClockHz;
	logic [31:0] memClockHz;
	logic [31:0] coreClockHz;
	logic [2:0] pllSettling;
	logic [7:0] expLow [3];
	logic [7:0] expMult [3];
	logic [31:0] rd;
	logic [1:0] rsp;
	tpdc_row_t rows [10];
	int badCount = 0;
	int checksDone = 0;
	int waitCount = 0;

	always #5 clk_sys = ~clk_sys;

	tpdc_clock_cfg #(.FIN_HZ(FIN)) u_dut (
		.clk_sys(clk_sys), .rst_n(rst_n), .axiReq(axiReq), .axiRsp(axiRsp),
		.srcPllCfg(srcCfg), .memPllCfg(memCfg), .corePllCfg(coreCfg), .srcExtraDiv(srcExtraDiv),
		.srcPllHz(srcPllHz), .scanClockHz(scanClockHz), .memClockHz(memClockHz),
		.coreClockHz(coreClockHz), .pllSettling(pllSettling)
	);

	task automatic report_and_stop();
		$display("checks %0d, mismatches %0d", checksDone, badCount);
		if (badCount == 0 && checksDone > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		checksDone++;
		if (got !== exp) begin
			badCount++;
			$display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask

	task automatic timed_out(input logic ok);
		if (!ok) begin
			badCount++;
			$display("unexpected at %0t: wait never completed", $time);
			report_and_stop();
		end
	endtask

	// entered right after a rising edge; payload held until each channel is taken
	task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
		output logic [1:0] r);
		logic awHit;
		logic wHit;
		logic bHit;
		int n;
		n = 0;
		bHit = 1'b0;
		axiReq.awvalid <= 1'b1;
		axiReq.awaddr <= a;
		axiReq.wvalid <= 1'b1;
		axiReq.wdata <= d;
		axiReq.wstrb <= s;
		axiReq.bready <= 1'b1;
		while (!bHit && n < 20) begin
			@(negedge clk_sys);
			awHit = axiReq.awvalid && axiRsp.awready;
			wHit = axiReq.wvalid && axiRsp.wready;
			bHit = axiRsp.bvalid === 1'b1;
			r = axiRsp.bresp;
			@(posedge clk_sys);
			if (awHit) axiReq.awvalid <= 1'b0;
			if (wHit) axiReq.wvalid <= 1'b0;
			n++;
		end
		axiReq.bready <= 1'b0;
		// one edge between transfers so no signal is driven twice at once
		@(posedge clk_sys);
		timed_out(bHit);
	endtask

	task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		logic arHit;
		logic rHit;
		int n;
		n = 0;
		rHit = 1'b0;
		axiReq.arvalid <= 1'b1;
		axiReq.araddr <= a;
		axiReq.rready <= 1'b1;
		while (!rHit && n < 20) begin
			@(negedge clk_sys);
			arHit = axiReq.arvalid && axiRsp.arready;
			rHit = axiRsp.rvalid === 1'b1;
			d = axiRsp.rdata;
			r = axiRsp.rresp;
			@(posedge clk_sys);
			if (arHit) axiReq.arvalid <= 1'b0;
			n++;
		end
		axiReq.rready <= 1'b0;
		@(posedge clk_sys);
		timed_out(rHit);
	endtask

	function automatic logic [31:0] exp_hz(input logic [7:0] low, input logic [7:0] mult);
		exp_hz = ((FIN >> low[0]) * ({26'h0, mult[5:0]} + 32'h1)) >> low[2:1];
	endfunction

	task automatic check_outputs();
		tpdc_pll_cfg_t c [3];
		logic [31:0] h [3];
		logic [2:0] sh;
		// frequencies trail the fields by one edge
		repeat (2) @(posedge clk_sys);
		@(negedge clk_sys);
		c[0] = srcCfg;
		c[1] = memCfg;
		c[2] = coreCfg;
		h[0] = srcPllHz;
		h[1] = memClockHz;
		h[2] = coreClockHz;
		for (int i = 0; i < 3; i++) begin
			chk({23'h0, c[i]}, {23'h0, expLow[i][0], expLow[i][2:1], expMult[i][5:0]}, "fields");
			chk(h[i], exp_hz(expLow[i], expMult[i]), "pll frequency");
		end
		sh = expLow[0][3] ? 3'h4 : {1'b0, expLow[0][5:4]};
		chk({29'h0, srcExtraDiv}, {29'h0, expLow[0][5:3]}, "extra code");
		chk(scanClockHz, exp_hz(expLow[0], expMult[0]) >> sh, "scan frequency");
		@(posedge clk_sys);
	endtask

	task automatic check_regs();
		for (int i = 0; i < 3; i++) begin
			axi_read(8'h14 + 8'(i * 8), rd, rsp);
			chk(rd, {24'h0, expLow[i]}, "low register");
			axi_read(8'h18 + 8'(i * 8), rd, rsp);
			chk(rd, {24'h0, expMult[i]}, "multiplier register");
		end
	endtask

	task automatic do_reset();
		rst_n <= 1'b0;
		repeat (4) @(posedge clk_sys);
		rst_n <= 1'b1;
		expLow = '{8'h04, 8'h02, 8'h04};
		expMult = '{8'h17, 8'h1D, 8'h2A};
		@(posedge clk_sys);
		check_outputs();
		check_regs();
	endtask

	initial begin
		// extra codes xx1, 000, 010, 100, 110 and every output divider code
		// multipliers never zero, PLLs taken as disabled while fields change
		rows[0] = '{8'h14, 32'h000000FF, 8'h3F};
		rows[1] = '{8'h14, 32'h00000000, 8'h00};
		rows[2] = '{8'h14, 32'h00000013, 8'h13};
		rows[3] = '{8'h14, 32'h00000025, 8'h25};
		rows[4] = '{8'h14, 32'h00000036, 8'h36};
		rows[5] = '{8'h1C, 32'hFFFFFFFF, 8'h07};
		rows[6] = '{8'h18, 32'h000000FF, 8'h3F};
		rows[7] = '{8'h20, 32'h00000001, 8'h01};
		rows[8] = '{8'h24, 32'h000000FA, 8'h02};
		rows[9] = '{8'h28, 32'h0000003F, 8'h3F};
		do_reset();
		foreach (rows[k]) begin
			axi_write(rows[k].addr, rows[k].wdata, 4'hF, rsp);
			chk({30'h0, rsp}, 32'h0, "write answer");
			axi_read(rows[k].addr, rd, rsp);
			chk(rd, {24'h0, rows[k].rdExp}, "readback");
			chk({30'h0, rsp}, 32'h0, "read answer");
			if (rows[k].addr[2]) begin
				expLow[(rows[k].addr - 8'h14) >> 3] = rows[k].rdExp;
			end else begin
				expMult[(rows[k].addr - 8'h18) >> 3] = rows[k].rdExp;
			end
			check_outputs();
		end
		// byte lane zero disabled: nothing stored
		axi_write(8'h18, 32'h00000001, 4'hE, rsp);
		chk({30'h0, rsp}, 32'h0, "masked write answer");
		check_regs();
		// unmapped place: error answer, no effect
		axi_write(8'h2C, 32'h000000FF, 4'hF, rsp);
		chk({30'h0, rsp}, {30'h0, `TPDC_RESP_SLVERR}, "unmapped write answer");
		axi_read(8'h2C, rd, rsp);
		chk({30'h0, rsp}, {30'h0, `TPDC_RESP_SLVERR}, "unmapped read answer");
		chk(rd, 32'h0, "unmapped read data");
		check_outputs();
		// second reset in mid-run restores the power-up values
		do_reset();
		// lock wait: only the memory PLL settles, then its output is relied on
		axi_write(8'h20, 32'h00000002, 4'hF, rsp);
		expMult[1] = 8'h02;
		axi_read(8'h40, rd, rsp);
		chk(rd, 32'h00000002, "status during lock wait");
		chk({29'h0, pllSettling}, 32'h00000002, "settling flags");
		waitCount = 0;
		while (pllSettling !== 3'h0 && waitCount < 4000) begin
			@(negedge clk_sys);
			waitCount++;
		end
		timed_out(pllSettling === 3'h0);
		chk({31'h0, (waitCount > `TPDC_LOCK_CYCLES - 20) && (waitCount <= `TPDC_LOCK_CYCLES)}, 32'h1,
			"lock wait length");
		check_outputs();
		report_and_stop();
	end
endmodule
`default_nettype wire

// >>> tpdc_defs.svh
// tpdc_defs.svh: register indices, field positions, reset values and timing of the PLL configuration block
// assumes every file of the block includes it by its bare name
`ifndef TPDC_DEFS_SVH
`define TPDC_DEFS_SVH

// register indices; byte address is four times the index
`define TPDC_IDX_SRC_LOW 8'h05
`define TPDC_IDX_SRC_MULT 8'h06
`define TPDC_IDX_MEM_LOW 8'h07
`define TPDC_IDX_MEM_MULT 8'h08
`define TPDC_IDX_CORE_LOW 8'h09
`define TPDC_IDX_CORE_MULT 8'h0A
`define TPDC_IDX_STATUS 8'h10

// pll numbering in the storage array
`define TPDC_PLL_SRC 2'h0
`define TPDC_PLL_MEM 2'h1
`define TPDC_PLL_CORE 2'h2

// field positions
`define TPDC_PRE_BIT 0
`define TPDC_OUT_LSB 1
`define TPDC_OUT_MSB 2
`define TPDC_EXTRA_LSB 3
`define TPDC_EXTRA_MSB 5
`define TPDC_MULT_LSB 0
`define TPDC_MULT_MSB 5

// reset values
`define TPDC_PRE_RST 1'h0
`define TPDC_EXTRA_RST 3'h0
`define TPDC_SRC_OUT_RST 2'h2
`define TPDC_MEM_OUT_RST 2'h1
`define TPDC_CORE_OUT_RST 2'h2
`define TPDC_SRC_MULT_RST 6'h17
`define TPDC_MEM_MULT_RST 6'h1D
`define TPDC_CORE_MULT_RST 6'h2A

// extra divider code xx1 means a shift of four
`define TPDC_EXTRA_DIV16_SHIFT 3'h4

// lock wait, rounded up to whole cycles
`define TPDC_LOCK_TIME_NS 30000
`define TPDC_CLK_PERIOD_NS 10
`define TPDC_LOCK_CYCLES ((`TPDC_LOCK_TIME_NS + `TPDC_CLK_PERIOD_NS - 1) / `TPDC_CLK_PERIOD_NS)
`define TPDC_LOCK_CNT_W 12

// bus answers
`define TPDC_RESP_OKAY 2'h0
`define TPDC_RESP_SLVERR 2'h2

`endif

// >>> tpdc_pkg.sv
// tpdc_pkg.sv: types shared by the PLL configuration block
// assumes tpdc_defs.svh is on the include path
`include "tpdc_defs.svh"

package tpdc_pkg;

	typedef struct packed {
		logic preDiv;
		logic [1:0] outDiv;
		logic [5:0] multiplier;
	} tpdc_pll_cfg_t;

	typedef struct packed {
		logic awvalid;
		logic [7:0] awaddr;
		logic wvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bready;
		logic arvalid;
		logic [7:0] araddr;
		logic rready;
	} tpdc_axil_req_t;

	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} tpdc_axil_rsp_t;

	// extra post-divider code to a right shift
	function automatic logic [2:0] tpdc_extra_shift(input logic [2:0] code);
		tpdc_extra_shift = code[0] ? `TPDC_EXTRA_DIV16_SHIFT : {1'b0, code[2:1]};
	endfunction

endpackage

// >>> tpdc_pll_freq.sv
// tpdc_pll_freq.sv: nominal output frequency of one PLL from its fields
// assumes one clock domain, synchronous active-low reset
`timescale 1ns/1ps
`default_nettype none
`include "tpdc_defs.svh"

module tpdc_pll_freq #(
	parameter int unsigned FIN_HZ = 12000000
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// divider fields
	input wire tpdc_pkg::tpdc_pll_cfg_t cfg,
	input wire logic [2:0] extraShift,
	// result in hertz
	output logic [31:0] freqHz
);
	import tpdc_pkg::*;

	logic [38:0] preHz;
	logic [38:0] vcoHz;
	logic [6:0] multPlusOne;
	logic [3:0] shiftTotal;

	assign preHz = 39'(FIN_HZ) >> cfg.preDiv;
	assign multPlusOne = {1'b0, cfg.multiplier} + 7'h01;
	assign vcoHz = preHz * {32'h0, multPlusOne};
	assign shiftTotal = {2'h0, cfg.outDiv} + {1'b0, extraShift};

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			freqHz <= 32'h0;
		end else begin
			freqHz <= 32'(vcoHz >> shiftTotal);
		end
	end

	AST_PLL_FREQ: assert property (@(posedge clk_sys) disable iff (!rst_n)
		$stable(cfg) && $stable(extraShift) |=> 64'(freqHz) == ((64'(FIN_HZ) / (64'h1 << $past(cfg.preDiv)))
			* (64'($past(cfg.multiplier)) + 64'h1)) / (64'h1 << (64'($past(cfg.outDiv)) + 64'($past(extraShift)))))
		else $error("pll frequency does not follow its fields");

endmodule
`default_nettype wire
